// file: core/sysctl_pkg.sv
package sysctl_pkg;

  // ==========================================================
  // bus map and answers
  // ==========================================================
  localparam logic [31:0] SYSCTL_OFS  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECODE = 2'h3;
  localparam int          LANE_LO     = 0;
  localparam int          LANE_HI     = 1;

  // ==========================================================
  // system control register layout
  // ==========================================================
  localparam int          MAC_BIT     = 13;
  localparam int          RAM_BIT     = 8;
  localparam int          FLASH_BIT   = 7;
  localparam int          DTC_BIT     = 1;
  localparam logic [15:0] FIXED_ONES  = 16'hd401;
  localparam logic [15:0] RESET_VALUE = 16'hd503;
  localparam logic        MAC_RST     = 1'h0;
  localparam logic        RAM_RST     = 1'h1;
  localparam logic        FLASH_RST   = 1'h0;
  localparam logic        DTC_RST     = 1'h1;

  // writable controls of the register
  typedef struct packed {
    logic mac_sat;
    logic ram_en;
    logic flash_en;
    logic dtc_short;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{MAC_RST, RAM_RST, FLASH_RST, DTC_RST};

  // bus answer state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } bus_state_e;

  // builds the 16-bit read view from the controls
  function automatic logic [15:0] view(input ctrl_s c);
    logic [15:0] v;
    v            = FIXED_ONES;
    v[MAC_BIT]   = c.mac_sat;
    v[RAM_BIT]   = c.ram_en;
    v[FLASH_BIT] = c.flash_en;
    v[DTC_BIT]   = c.dtc_short;
    return v;
  endfunction : view

endpackage : sysctl_pkg

// file: core/system_control.sv
`timescale 1ns/1ps

// Operation
// - bit 13 selects multiply-accumulate saturation, 1 saturates; resets to 0
// - bits 15 and 14 read 1 always, writes ignored
// - bit 12 reads 1 always, writes ignored
// - bits 11 and 9 read 0; software writes 0 there
// - bit 10 reads 1; software writes 1 there
// - bit 8 enables on-chip RAM, 0 disables it
// - RAM enable is 1 when reset is released
// - flash control registers reachable only while bit 7 is 1; resets to 0
// - clearing bit 7 keeps flash control register contents
// - bits 6 to 2 read 0; software writes 0 there
// - bit 1 selects transfer addressing: 0 full, 1 short; resets to 1
// - bit 0 reads 1; software writes 1 there
module system_control #(
  parameter int ADDR_W = 4
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic      [1:0]        response,
  output logic                   waitrequest,
  output logic                   mac_saturate_select,
  output logic                   onchip_memory_enable,
  output logic                   flash_regs_access_enable,
  output logic                   transfer_ctrl_addr_mode,
  input  wire logic              flash_acc_req,
  output logic                   flash_acc_grant
);

  // ==========================================================
  // elaboration checks
  // ==========================================================
  if (ADDR_W < 2 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("ADDR_W must lie between 2 and 32");
  end

  // ==========================================================
  // state
  // ==========================================================
  sysctl_pkg::bus_state_e state_reg;
  sysctl_pkg::bus_state_e state_next;
  logic                   hit_reg;
  logic                   hit_next;
  logic                   wait_reg;
  logic                   wait_next;
  logic [31:0]            rdata_reg;
  logic [31:0]            rdata_next;
  logic [1:0]             resp_reg;
  logic [1:0]             resp_next;
  sysctl_pkg::ctrl_s      ctrl_reg;
  sysctl_pkg::ctrl_s      ctrl_next;
  logic                   grant_reg;
  logic                   grant_next;
  logic                   addr_hit;
  logic                   commit_wr;

  // register is mapped at one aligned word
  assign addr_hit = (address == sysctl_pkg::SYSCTL_OFS[ADDR_W-1:0]);

  // write takes effect only at the edge where waitrequest is low
  assign commit_wr = (state_reg == sysctl_pkg::ST_ANSWER) && write && hit_reg;

  // ==========================================================
  // bus slave: one wait cycle, then the answer
  // ==========================================================
  always_comb
  begin
    state_next = state_reg;
    hit_next   = hit_reg;
    wait_next  = wait_reg;
    rdata_next = rdata_reg;
    resp_next  = resp_reg;
    unique case (state_reg)
      sysctl_pkg::ST_IDLE:
      begin
        if (read || write)
        begin
          state_next = sysctl_pkg::ST_ANSWER;
          hit_next   = addr_hit;
          wait_next  = 1'b0;
          resp_next  = addr_hit ? sysctl_pkg::RESP_OKAY : sysctl_pkg::RESP_DECODE;
          if (read)
          begin
            // fixed bits come from the view, unmapped reads return zero
            rdata_next = addr_hit ? {16'h0000, sysctl_pkg::view(ctrl_reg)}
                                  : 32'h0000_0000;
          end
        end
      end
      sysctl_pkg::ST_ANSWER:
      begin
        state_next = sysctl_pkg::ST_IDLE;
        wait_next  = 1'b1;
      end
      default:
      begin
        state_next = sysctl_pkg::ST_IDLE;
        wait_next  = 1'b1;
      end
    endcase
  end

  // bus slave registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= sysctl_pkg::ST_IDLE;
      hit_reg   <= 1'b0;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= sysctl_pkg::RESP_OKAY;
    end
    else
    begin
      state_reg <= state_next;
      hit_reg   <= hit_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
      resp_reg  <= resp_next;
    end
  end

  // ==========================================================
  // control bits
  // ==========================================================
  // only the four controls are stored; reserved bits ignore writes
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (commit_wr)
    begin
      if (byteenable[sysctl_pkg::LANE_HI])
      begin
        ctrl_next.mac_sat = writedata[sysctl_pkg::MAC_BIT];
        ctrl_next.ram_en  = writedata[sysctl_pkg::RAM_BIT];
      end
      if (byteenable[sysctl_pkg::LANE_LO])
      begin
        ctrl_next.flash_en  = writedata[sysctl_pkg::FLASH_BIT];
        ctrl_next.dtc_short = writedata[sysctl_pkg::DTC_BIT];
      end
    end
  end

  // controls take their initial values while reset is held
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= sysctl_pkg::CTRL_RST;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================================
  // flash control register gate
  // ==========================================================
  // grant only while enabled; nothing is cleared when disabled
  always_comb
  begin
    grant_next = flash_acc_req && ctrl_reg.flash_en;
  end

  // gate register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      grant_reg <= 1'b0;
    end
    else
    begin
      grant_reg <= grant_next;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign readdata                 = rdata_reg;
  assign response                 = resp_reg;
  assign waitrequest              = wait_reg;
  assign mac_saturate_select      = ctrl_reg.mac_sat;
  assign onchip_memory_enable     = ctrl_reg.ram_en;
  assign flash_regs_access_enable = ctrl_reg.flash_en;
  assign transfer_ctrl_addr_mode  = ctrl_reg.dtc_short;
  assign flash_acc_grant          = grant_reg;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // marks the first cycle after reset release
  logic first_reg;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_reg <= 1'b1;
    end
    else
    begin
      first_reg <= 1'b0;
    end
  end

  logic rd_ans;
  assign rd_ans = (state_reg == sysctl_pkg::ST_ANSWER) && read && hit_reg;

  a_mac_write_lands: assert property (
    commit_wr && byteenable[1] |=> mac_saturate_select == $past(writedata[13]))
    else $error("mac select did not take written value");

  a_ro_top_ones: assert property (
    rd_ans |-> readdata[15:14] == 2'h3)
    else $error("bits 15:14 did not read as ones");

  a_ro_bit_twelve: assert property (
    rd_ans |-> readdata[12])
    else $error("bit 12 did not read as one");

  a_rsv_zero_mid: assert property (
    rd_ans |-> !readdata[11] && !readdata[9])
    else $error("bits 11 or 9 read as one");

  a_rsv_one_ten: assert property (
    rd_ans |-> readdata[10])
    else $error("bit 10 did not read as one");

  a_ram_write_lands: assert property (
    commit_wr && byteenable[1] |=> onchip_memory_enable == $past(writedata[8]))
    else $error("ram enable did not take written value");

  a_ram_reset_one: assert property (
    first_reg |-> onchip_memory_enable)
    else $error("ram enable not set after reset");

  a_flash_gate_holds: assert property (
    flash_acc_grant |-> $past(flash_acc_req) && $past(flash_regs_access_enable))
    else $error("flash access granted while disabled");

  a_flash_gate_opens: assert property (
    flash_acc_req && flash_regs_access_enable |=> flash_acc_grant)
    else $error("flash access not granted while enabled");

  a_decode_answer: assert property (
    !waitrequest && !hit_reg |-> response == sysctl_pkg::RESP_DECODE)
    else $error("unmapped access not answered with decode error");

  a_rsv_low_bits: assert property (
    rd_ans |-> readdata[6:2] == 5'h00 && readdata[31:16] == 16'h0000)
    else $error("reserved low bits read nonzero");

  a_dtc_write_lands: assert property (
    commit_wr && byteenable[0] |=> transfer_ctrl_addr_mode == $past(writedata[1]))
    else $error("transfer mode did not take written value");

  a_rsv_bit_zero: assert property (
    rd_ans |-> readdata[0])
    else $error("bit 0 did not read as one");

  a_reset_view: assert property (
    first_reg |-> sysctl_pkg::view(ctrl_reg) == sysctl_pkg::RESET_VALUE)
    else $error("register view differs from reset value");

  a_ctrl_hold_idle: assert property (
    !commit_wr |=> $stable(ctrl_reg))
    else $error("controls changed without a committed write");

  a_wait_one_cycle: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  c_write_then_read: cover property (
    commit_wr ##[1:20] rd_ans);

  c_flash_granted: cover property (
    flash_acc_req && flash_regs_access_enable ##1 flash_acc_grant);

  c_flash_refused: cover property (
    flash_acc_req && !flash_regs_access_enable ##1 !flash_acc_grant);

  c_unmapped_access: cover property (
    !waitrequest && response == sysctl_pkg::RESP_DECODE);

endmodule : system_control

// file: testbench/system_control_bench.sv
`timescale 1ns/1ps

module system_control_bench;
  // ==========================================================
  // clock, reset and register bus signals
  // ==========================================================
  logic        mclk;
  logic        arst_n;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic [1:0]  response;
  logic        waitrequest;
  logic        mac_saturate_select;
  logic        onchip_memory_enable;
  logic        flash_regs_access_enable;
  logic        transfer_ctrl_addr_mode;
  logic        flash_acc_req;
  logic        flash_acc_grant;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          fails;
  int          tests_run;

  system_control #(.ADDR_W(4)) dut (
    .mclk                     (mclk),
    .arst_n                   (arst_n),
    .address                  (address),
    .read                     (read),
    .write                    (write),
    .writedata                (writedata),
    .byteenable               (byteenable),
    .readdata                 (readdata),
    .response                 (response),
    .waitrequest              (waitrequest),
    .mac_saturate_select      (mac_saturate_select),
    .onchip_memory_enable     (onchip_memory_enable),
    .flash_regs_access_enable (flash_regs_access_enable),
    .transfer_ctrl_addr_mode  (transfer_ctrl_addr_mode),
    .flash_acc_req            (flash_acc_req),
    .flash_acc_grant          (flash_acc_grant)
  );

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // ==========================================================
  // compare and closing tasks
  // ==========================================================
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // ==========================================================
  // avalon access: hold the request until waitrequest is seen low
  // ==========================================================
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge mclk);
    read       <= ~wr;
    write      <= wr;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (waitrequest === 1'b0)
        break;
    end
    rd = readdata;
    rsp = response;
    read  <= 1'b0;
    write <= 1'b0;
    if (n == 20)
    begin
      fails++;
      $display("ERROR waitrequest expected 0 seen 1");
      results();
    end
  endtask : bus

  // read the register and compare view and answer code
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    bus(1'b0, a, 32'h0, 4'h0);
    check("readdata", exp, rd);
    check("response", {30'h0, er}, {30'h0, rsp});
  endtask : rd_chk

  // control levels in order mac, ram, flash, dtc
  task automatic outs(input logic [3:0] exp);
    @(negedge mclk);
    check("controls", {28'h0, exp}, {28'h0, mac_saturate_select, onchip_memory_enable,
          flash_regs_access_enable, transfer_ctrl_addr_mode});
  endtask : outs

  // grant follows the request one cycle later, gated by bit 7
  task automatic gate(input logic exp);
    @(posedge mclk);
    @(negedge mclk);
    check("grant", {31'h0, exp}, {31'h0, flash_acc_grant});
  endtask : gate

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    mclk = 1'b0;
    arst_n = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
    flash_acc_req = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    outs(4'b0101);
    rd_chk(4'h0, 32'h0000d503, sysctl_pkg::RESP_OKAY);
    // all controls set; read-only bits written 0 must stay 1
    bus(1'b1, 4'h0, 32'h00002583, 4'hf);
    outs(4'b1111);
    rd_chk(4'h0, 32'h0000f583, sysctl_pkg::RESP_OKAY);
    bus(1'b1, 4'h0, 32'h00000401, 4'hf);
    outs(4'b0000);
    rd_chk(4'h0, 32'h0000d401, sysctl_pkg::RESP_OKAY);
    // byte lanes one at a time, then none
    bus(1'b1, 4'h0, 32'h00002583, 4'h2);
    rd_chk(4'h0, 32'h0000f501, sysctl_pkg::RESP_OKAY);
    bus(1'b1, 4'h0, 32'h00002583, 4'h1);
    rd_chk(4'h0, 32'h0000f583, sysctl_pkg::RESP_OKAY);
    bus(1'b1, 4'h0, 32'h00000401, 4'h0);
    rd_chk(4'h0, 32'h0000f583, sysctl_pkg::RESP_OKAY);
    // unmapped address: decode error, write ignored
    bus(1'b1, 4'h4, 32'h00000401, 4'hf);
    rd_chk(4'h4, 32'h0, sysctl_pkg::RESP_DECODE);
    rd_chk(4'h0, 32'h0000f583, sysctl_pkg::RESP_OKAY);
    // flash control access granted only while bit 7 is set
    @(posedge mclk);
    flash_acc_req <= 1'b1;
    gate(1'b1);
    bus(1'b1, 4'h0, 32'h00002503, 4'hf);
    outs(4'b1101);
    gate(1'b0);
    // second reset in mid-run
    @(posedge mclk);
    arst_n <= 1'b0;
    outs(4'b0101);
    check("waitrequest", 32'h1, {31'h0, waitrequest});
    check("grant", 32'h0, {31'h0, flash_acc_grant});
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    flash_acc_req <= 1'b0;
    rd_chk(4'h0, 32'h0000d503, sysctl_pkg::RESP_OKAY);
    results();
  end
endmodule : system_control_bench
